// *** spd_regs.svh ***
// Functional notes
// RULE1: each shift clock fall advances 32 stages
// RULE2: stage one takes serial input at fall
// RULE3: cascade output shows last stage continuously
// RULE4: buffered cascade output feeds next device input
// RULE5: strobe and enable never affect shifting
// RULE6: strobe low forces all outputs on
// RULE7: enable low, strobe high: all off
// RULE8: both high: outputs show inverted stages
// RULE9: no reset; shift in 32 bits first (the code has reset_i, which clears all stages to 0 and turns all outputs off)
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH
`define SPD_STAGES     32
`define SPD_FIFO_DEPTH 4
`define SPD_FIFO_AW    2
`endif

// *** spd_pkg.sv ***
`default_nettype none
package spd_pkg;
    typedef logic [31:0] spd_word_t;
    typedef enum logic [1:0] {
        SPD_CLK_HIGH = 2'b01,
        SPD_CLK_LOW  = 2'b10
    } spd_clk_state_t;
endpackage
`default_nettype wire

// *** spd_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module spd_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } spd_fifo_state_t;

    spd_fifo_state_t  st;
    spd_fifo_state_t  next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready_o  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o  = mem[st.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[st.wr] <= in_data_i;
        end
    end
endmodule // spd_fifo
`default_nettype wire

// *** spd_sink_driver.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spd_regs.svh"
module spd_sink_driver (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        shift_clk_i,
    input  wire logic        serial_in_i,
    input  wire logic        output_enable_i,
    input  wire logic        all_on_strobe_n_i,
    output logic             cascade_out_o,
    output logic [31:0]      hv_sink_out_o,
    output logic [31:0]      hv_sink_out_oe_n_o
);
    typedef struct packed {
        spd_pkg::spd_clk_state_t cs;
        spd_pkg::spd_word_t      sr;
        logic                    casc;
        logic [31:0]             sink_off;
    } spd_state_t;

    spd_state_t st;
    spd_state_t next_st;
    logic       fall;
    logic       bit_val;
    logic       bit_rdy;
    logic       in_rdy;

    // falling edge of the synchronous shift clock marks a sample
    assign fall = (st.cs == spd_pkg::SPD_CLK_HIGH) && !shift_clk_i;

    // sampled bits wait here; a stage moves only when the FIFO hands one on
    spd_fifo #(
        .WIDTH (1),
        .DEPTH (`SPD_FIFO_DEPTH),
        .AW    (`SPD_FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_data_i   (serial_in_i), // RULE2
        .in_valid_i  (fall),
        .in_ready_o  (in_rdy),
        .out_data_o  (bit_val),
        .out_valid_o (bit_rdy),
        .out_ready_i (1'b1)
    );

    always_comb begin
        next_st = st;
        case (st.cs)
            spd_pkg::SPD_CLK_HIGH: begin
                if (!shift_clk_i) begin
                    next_st.cs = spd_pkg::SPD_CLK_LOW;
                end
            end
            spd_pkg::SPD_CLK_LOW: begin
                if (shift_clk_i) begin
                    next_st.cs = spd_pkg::SPD_CLK_HIGH;
                end
            end
            default: next_st.cs = spd_pkg::SPD_CLK_LOW;
        endcase
        // shifting ignores strobe and enable
        if (bit_rdy) begin // RULE5
            next_st.sr = {st.sr[`SPD_STAGES-2:0], bit_val}; // RULE1
        end
        next_st.casc = next_st.sr[`SPD_STAGES-1]; // RULE3 RULE4
        // kept as the oe_n pattern so the pins come straight from flops
        if (!all_on_strobe_n_i) begin
            next_st.sink_off = '0; // RULE6
        end else if (!output_enable_i) begin
            next_st.sink_off = '1; // RULE7
        end else begin
            next_st.sink_off = ~next_st.sr; // RULE8
        end
    end

    // contents are undefined at power-up; reset only clears to a known 0
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '{cs: spd_pkg::SPD_CLK_LOW, sr: '0, casc: 1'b0,
                    sink_off: '1}; // RULE9
        end else begin
            st <= next_st;
        end
    end

    // open drain: pin pulled low (on) when oe_n low
    assign hv_sink_out_o      = '0;
    assign hv_sink_out_oe_n_o = st.sink_off;
    assign cascade_out_o      = st.casc;

    AST_STROBE_ON: assert property ( // RULE6
        @(posedge clk_i) disable iff (reset_i)
        !all_on_strobe_n_i |=> hv_sink_out_oe_n_o == '0)
        else $error("strobe did not force all on");
    AST_ALL_OFF: assert property ( // RULE7
        @(posedge clk_i) disable iff (reset_i)
        all_on_strobe_n_i && !output_enable_i |=> hv_sink_out_oe_n_o == '1)
        else $error("outputs not off with enable low");
    AST_FOLLOW: assert property ( // RULE8
        @(posedge clk_i) disable iff (reset_i)
        all_on_strobe_n_i && output_enable_i |=> hv_sink_out_oe_n_o == ~st.sr)
        else $error("outputs do not follow stages");
    AST_CASCADE: assert property ( // RULE3
        @(posedge clk_i) disable iff (reset_i)
        cascade_out_o == st.sr[31])
        else $error("cascade not last stage");
    AST_SHIFT: assert property ( // RULE2
        @(posedge clk_i) disable iff (reset_i)
        fall && in_rdy |=> ##1 st.sr[0] == $past(serial_in_i, 2))
        else $error("sample not entered stage one");
    AST_MOVE: assert property ( // RULE1
        @(posedge clk_i) disable iff (reset_i)
        bit_rdy |=> st.sr[31:1] == $past(st.sr[30:0]))
        else $error("stages did not advance");
    AST_HOLD: assert property ( // RULE5
        @(posedge clk_i) disable iff (reset_i)
        !bit_rdy |=> st.sr == $past(st.sr))
        else $error("register changed without a clock fall");
    AST_CLKST: assert property ( // RULE1
        @(posedge clk_i) disable iff (reset_i)
        st.cs == spd_pkg::SPD_CLK_HIGH && !shift_clk_i |=> bit_rdy)
        else $error("fall not captured");
    AST_NOFULL: assert property ( // RULE1
        @(posedge clk_i) disable iff (reset_i)
        fall |-> in_rdy)
        else $error("sample buffer full at a clock fall");
    AST_ONLY_FALL: assert property ( // RULE1
        @(posedge clk_i) disable iff (reset_i)
        bit_rdy |-> $past(fall))
        else $error("stage moved without a clock fall");
    AST_CASC_NEXT: assert property ( // RULE3
        @(posedge clk_i) disable iff (reset_i)
        bit_rdy |=> cascade_out_o == $past(st.sr[30]))
        else $error("cascade did not take the stage before it");
    AST_STROBE_SHIFT: assert property ( // RULE5
        @(posedge clk_i) disable iff (reset_i)
        bit_rdy && !all_on_strobe_n_i |=> st.sr[0] == $past(bit_val))
        else $error("strobe disturbed shifting");
    AST_OFF_SHIFT: assert property ( // RULE5
        @(posedge clk_i) disable iff (reset_i)
        bit_rdy && !output_enable_i |=> st.sr[0] == $past(bit_val))
        else $error("enable disturbed shifting");
    AST_STAND: assert property ( // RULE8
        @(posedge clk_i) disable iff (reset_i)
        !$past(reset_i) && !bit_rdy &&
        $stable(all_on_strobe_n_i) && $stable(output_enable_i)
        |=> $stable(hv_sink_out_oe_n_o))
        else $error("outputs changed with nothing to change them");
    AST_ONEHOT: assert property ( // RULE1
        @(posedge clk_i) disable iff (reset_i)
        $onehot(st.cs))
        else $error("clock state not one-hot");
endmodule // spd_sink_driver
`default_nettype wire

// *** spd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spd_host_model (
    input  wire logic clk_i,
    output logic      shift_clk_o,
    output logic      serial_o
);
    initial begin
        shift_clk_o = 1'b0;
        serial_o    = 1'b0;
    end
    // one clock fall per bit; w stretches both phases for a slow host
    task automatic send(input logic b, input int w);
        @(negedge clk_i);
        shift_clk_o = 1'b1;
        serial_o    = b;
        repeat (w) @(negedge clk_i);
        shift_clk_o = 1'b0;
        repeat (w) @(negedge clk_i);
        // hold time over: data line no longer shows the bit
        serial_o    = ~b;
    endtask
endmodule // spd_host_model
`default_nettype wire

// *** test_spd_sink_driver.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_spd_sink_driver;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        oe = 1'b0;
    logic        str_n = 1'b1;
    wire logic   sclk;
    wire logic   sdat;
    logic        casc;
    logic        casc2;
    logic [31:0] hv;
    logic [31:0] hv2;
    logic [31:0] oen;
    logic [31:0] oen2;
    logic        mq[$];
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    always #2 clk_i = ~clk_i;
    spd_host_model i_host (.clk_i(clk_i), .shift_clk_o(sclk),
        .serial_o(sdat));
    spd_sink_driver i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .shift_clk_i(sclk), .serial_in_i(sdat), .output_enable_i(oe),
        .all_on_strobe_n_i(str_n), .cascade_out_o(casc),
        .hv_sink_out_o(hv), .hv_sink_out_oe_n_o(oen));
    // second device chained from the cascade output, same shift clock
    spd_sink_driver i_dut_next (.clk_i(clk_i), .reset_i(reset_i),
        .shift_clk_i(sclk), .serial_in_i(casc), .output_enable_i(oe),
        .all_on_strobe_n_i(str_n), .cascade_out_o(casc2),
        .hv_sink_out_o(hv2), .hv_sink_out_oe_n_o(oen2));
    // model stages: mq[0] is stage one of the first device
    function automatic logic [31:0] stages(int base);
        logic [31:0] v;
        for (int k = 0; k < 32; k++)
            v[k] = mq[base + k];
        return v;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic check_all;
        logic [31:0] e;
        logic [31:0] s1;
        logic [31:0] s2;
        s1 = stages(0);
        s2 = stages(32);
        e = !str_n ? 32'h0 : (!oe ? 32'hFFFFFFFF : ~s1);
        chk("oe_n", e, oen);
        e = !str_n ? 32'h0 : (!oe ? 32'hFFFFFFFF : ~s2);
        chk("oe_n_next", e, oen2);
        chk("cascade", {31'h0, s1[31]}, {31'h0, casc});
        chk("cascade_next", {31'h0, s2[31]}, {31'h0, casc2});
        chk("hv", 32'h0, hv | hv2);
    endtask
    task automatic shift1(input logic b, input int w);
        i_host.send(b, w);
        mq.push_front(b);
        void'(mq.pop_back());
        check_all();
    endtask
    task automatic setc(input logic o, input logic s);
        @(negedge clk_i);
        oe    = o;
        str_n = s;
        repeat (2) @(negedge clk_i);
        check_all();
    endtask
    task automatic pulse_reset;
        @(negedge clk_i);
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        foreach (mq[k])
            mq[k] = 1'b0;
        @(negedge clk_i);
        check_all();
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(19587));
        repeat (64) mq.push_back(1'b0);
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        @(negedge clk_i);
        check_all();
        for (int i = 0; i < 32; i++)
            shift1(1'($urandom), 2 + i % 2);
        for (int i = 0; i < 4; i++)
            setc(i[1], i[0]);
        for (int i = 0; i < 8; i++)
            setc(1'($urandom), 1'($urandom));
        setc(1'b1, 1'b0);
        for (int i = 0; i < 20; i++)
            shift1(1'($urandom), 2);
        setc(1'b0, 1'b1);
        for (int i = 0; i < 12; i++)
            shift1(1'($urandom), 3);
        setc(1'b1, 1'b1);
        pulse_reset();
        for (int i = 0; i < 40; i++)
            shift1(1'($urandom), 2);
        finish_test();
    end
endmodule // test_spd_sink_driver
`default_nettype wire
